/* rtl/acc_comparator_control.sv */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Comparator control and status with an AHB-Lite slave.
// -----------------------------------------------------------------------------
module acc_comparator_control (
    // Clock and reset.
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    // Register bus.
    input  wire acc_pkg::acc_ahb_req_type ahbReq,
    output var  acc_pkg::acc_ahb_rsp_type ahbRsp,
    // Analog comparator core.
    input  wire logic                    rawResult,
    output var  acc_pkg::acc_analog_type analogCtrl,
    // Converter state, same clock.
    input  wire logic                    converterEnable,
    input  wire logic [2:0]              channelSelect,
    output var  logic [2:0]              converterTriggerSelect,
    // Processor interrupt, same clock.
    input  wire logic                    globalIntEnable,
    input  wire logic                    vectorTaken,
    output var  logic                    compIntRequest,
    output var  logic                    irqLine,
    // Timer input capture.
    output var  logic                    captureSelect,
    output var  logic                    captureSignal,
    // Comparator output pin.
    output var  logic                    compOutPin,
    output var  logic                    compOutPinOe,
    // Pin digital paths.
    input  wire logic                    posPinDigital,
    input  wire logic                    negPinDigital,
    output var  logic                    posPortBit,
    output var  logic                    negPortBit
);

    import acc_pkg::*;

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------

    typedef struct packed {
        logic          compDisable;
        logic          bandgapSel;
        logic          intFlag;
        logic          intEnable;
        logic          capEnable;
        acc_edge_type  edgeSel;
        logic          muxEnable;
        logic [2:0]    trigSel;
        logic          outPinEnable;
        logic          negDigDisable;
        logic          posDigDisable;
        logic [1:0]    irqStatus;
        logic [1:0]    irqMask;
        logic          resultPrev;
        acc_phase_type phase;
        logic [7:0]    phaseIdx;
        logic          phaseMapped;
        acc_ahb_rsp_type rsp;
        acc_analog_type  analog;
        logic          intReq;
        logic          irq;
        logic          capSel;
        logic          capSig;
        logic          outPin;
        logic          outPinOe;
        logic          posPort;
        logic          negPort;
    } acc_state_type;

    acc_state_type state_q;
    acc_state_type state_d;

    // -------------------------------------------------------------------------
    // Synchronisers
    // -------------------------------------------------------------------------

    logic [2:0] syncVec;
    logic       resultSync;
    logic       posPinSync;
    logic       negPinSync;

    // Result and pin levels are asynchronous.
    acc_sync #(
        .WIDTH   (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn ({rawResult, posPinDigital, negPinDigital}),
        .syncOut (syncVec)
    );

    assign resultSync = syncVec[2]; // [RULE_07]
    assign posPinSync = syncVec[1];
    assign negPinSync = syncVec[0];

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------

    logic       addrTaken;
    logic [7:0] addrIdx;
    logic       addrMapped;

    // Taken when selected, active and ready.
    assign addrTaken = ahbReq.hsel && ahbReq.hready &&
                       (ahbReq.htrans == ACC_HTRANS_NONSEQ || ahbReq.htrans == ACC_HTRANS_SEQ);
    assign addrIdx   = ahbReq.haddr[9:2];

    // Only the six register words, aligned, in the window decode.
    always_comb begin
        addrMapped = 1'b0;
        if (ahbReq.haddr[31:10] == 22'h00_0000 && ahbReq.haddr[1:0] == 2'b00) begin
            case (addrIdx)
                ACC_IDX_CTRL_STATUS,
                ACC_IDX_OUT_CTRL,
                ACC_IDX_IRQ_STATUS,
                ACC_IDX_IRQ_MASK,
                ACC_IDX_CONV_CTRL_B,
                ACC_IDX_DIG_DISABLE: addrMapped = 1'b1;
                default:             addrMapped = 1'b0;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Register read view
    // -------------------------------------------------------------------------

    logic [7:0] readByte;

    // Unused bits read zero.
    always_comb begin
        readByte = 8'h00;
        case (state_q.phaseIdx)
            ACC_IDX_CTRL_STATUS: begin
                readByte[ACC_BIT_DISABLE] = state_q.compDisable;
                readByte[ACC_BIT_BANDGAP] = state_q.bandgapSel;
                readByte[ACC_BIT_OUTPUT]  = resultSync;              // [RULE_07]
                readByte[ACC_BIT_FLAG]    = state_q.intFlag;
                readByte[ACC_BIT_INT_EN]  = state_q.intEnable;
                readByte[ACC_BIT_CAP_EN]  = state_q.capEnable;
                readByte[ACC_BIT_EDGE_HI:ACC_BIT_EDGE_LO] = state_q.edgeSel;
            end
            ACC_IDX_OUT_CTRL: begin
                readByte[ACC_BIT_OUT_EN] = state_q.outPinEnable;     // [RULE_16]
            end
            ACC_IDX_IRQ_STATUS: begin
                readByte[1:0] = state_q.irqStatus;
            end
            ACC_IDX_IRQ_MASK: begin
                readByte[1:0] = state_q.irqMask;
            end
            ACC_IDX_CONV_CTRL_B: begin
                readByte[ACC_BIT_MUX_EN]    = state_q.muxEnable;
                readByte[ACC_BIT_TRIG_HI:0] = state_q.trigSel;
            end
            ACC_IDX_DIG_DISABLE: begin
                readByte[ACC_BIT_NEG_DDIS] = state_q.negDigDisable;  // [RULE_16]
                readByte[ACC_BIT_POS_DDIS] = state_q.posDigDisable;
            end
            default: readByte = 8'h00;
        endcase
    end

    // -------------------------------------------------------------------------
    // Events
    // -------------------------------------------------------------------------

    logic resultChange;
    logic edgeEvent;

    // Edges from consecutive synchronised samples.
    assign resultChange = resultSync ^ state_q.resultPrev; // [RULE_19]

    // Reserved code raises no event.
    always_comb begin
        case (state_q.edgeSel)
            ACC_EDGE_TOGGLE:  edgeEvent = resultChange;                       // [RULE_12] [RULE_19]
            ACC_EDGE_FALLING: edgeEvent = resultChange && !resultSync;        // [RULE_12]
            ACC_EDGE_RISING:  edgeEvent = resultChange && resultSync;         // [RULE_12]
            default:          edgeEvent = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------

    logic       wrStrobe;
    logic [7:0] wrByte;
    logic       flagClear;
    logic [1:0] irqClear;
    logic       negFromMux;

    assign wrStrobe = (state_q.phase == ACC_PH_WRITE) && state_q.phaseMapped;
    assign wrByte   = ahbReq.hwdata[7:0];

    // Write-one-to-clear strobes.
    assign flagClear = vectorTaken ||                                          // [RULE_09]
                       (wrStrobe && state_q.phaseIdx == ACC_IDX_CTRL_STATUS && wrByte[ACC_BIT_FLAG]);
    assign irqClear  = (wrStrobe && state_q.phaseIdx == ACC_IDX_IRQ_STATUS) ? wrByte[1:0] : 2'b00;

    // Mux feeds the negative input only with the converter off.
    assign negFromMux = state_q.muxEnable && !converterEnable; // [RULE_02] [RULE_03]

    always_comb begin
        state_d = state_q;

        // Data-phase writes.
        if (wrStrobe) begin
            case (state_q.phaseIdx)
                ACC_IDX_CTRL_STATUS: begin
                    state_d.compDisable = wrByte[ACC_BIT_DISABLE];  // [RULE_05]
                    state_d.bandgapSel  = wrByte[ACC_BIT_BANDGAP];  // [RULE_06]
                    state_d.intEnable   = wrByte[ACC_BIT_INT_EN];
                    state_d.capEnable   = wrByte[ACC_BIT_CAP_EN];
                    state_d.edgeSel     = acc_edge_type'(wrByte[ACC_BIT_EDGE_HI:ACC_BIT_EDGE_LO]);
                end
                ACC_IDX_OUT_CTRL: begin
                    state_d.outPinEnable = wrByte[ACC_BIT_OUT_EN];  // [RULE_04] [RULE_16]
                end
                ACC_IDX_IRQ_MASK: begin
                    state_d.irqMask = wrByte[1:0];
                end
                ACC_IDX_CONV_CTRL_B: begin
                    state_d.muxEnable = wrByte[ACC_BIT_MUX_EN];    // [RULE_03]
                    state_d.trigSel   = wrByte[ACC_BIT_TRIG_HI:0];
                end
                ACC_IDX_DIG_DISABLE: begin
                    state_d.negDigDisable = wrByte[ACC_BIT_NEG_DDIS]; // [RULE_15] [RULE_16]
                    state_d.posDigDisable = wrByte[ACC_BIT_POS_DDIS];
                end
                default: ;
            endcase
        end

        // Sticky flags: set beats clear.
        state_d.intFlag = (state_q.intFlag && !flagClear) || edgeEvent;        // [RULE_08] [RULE_09]
        state_d.irqStatus[ACC_EVT_EDGE] =
            (state_q.irqStatus[ACC_EVT_EDGE] && !irqClear[ACC_EVT_EDGE]) || edgeEvent;
        state_d.irqStatus[ACC_EVT_CHANGE] =
            (state_q.irqStatus[ACC_EVT_CHANGE] && !irqClear[ACC_EVT_CHANGE]) || resultChange;
        state_d.resultPrev = resultSync;                                        // [RULE_19]

        // Reads wait one cycle so a preceding write is seen.
        state_d.rsp.hresp = ACC_HRESP_OKAY;
        case (state_q.phase)
            ACC_PH_READ: begin
                state_d.rsp.hreadyout = 1'b1;
                state_d.rsp.hrdata    = {24'h00_0000, readByte};
                state_d.phase         = ACC_PH_IDLE;
            end
            ACC_PH_WRITE,
            ACC_PH_IDLE: begin
                state_d.rsp.hreadyout = 1'b1;
                if (addrTaken) begin
                    state_d.phaseIdx    = addrIdx;
                    state_d.phaseMapped = addrMapped;
                    if (ahbReq.hwrite) begin
                        state_d.phase = ACC_PH_WRITE;
                    end else begin
                        state_d.phase         = ACC_PH_READ;
                        state_d.rsp.hreadyout = 1'b0;
                    end
                end else begin
                    state_d.phase = ACC_PH_IDLE;
                end
            end
            default: begin
                state_d.phase         = ACC_PH_IDLE;
                state_d.rsp.hreadyout = 1'b1;
            end
        endcase

        // Analog core controls.
        state_d.analog.powerOff   = state_d.compDisable;                        // [RULE_05]
        state_d.analog.posBandgap = state_d.bandgapSel;                         // [RULE_01] [RULE_06]
        state_d.analog.negFromMux = negFromMux;                                 // [RULE_01] [RULE_02]
        state_d.analog.negChannel = negFromMux ? channelSelect : 3'b000;        // [RULE_02]

        // Interrupt outputs.
        state_d.intReq = state_d.intFlag && state_d.intEnable && globalIntEnable; // [RULE_10] [RULE_18]
        state_d.irq    = |(state_d.irqStatus & state_d.irqMask);

        // Result routing.
        state_d.capSel   = state_d.capEnable;                                   // [RULE_11]
        state_d.capSig   = state_d.capEnable && resultSync;                     // [RULE_11]
        state_d.outPinOe = state_d.outPinEnable;                                // [RULE_04]
        state_d.outPin   = state_d.outPinEnable && resultSync;                  // [RULE_04]

        // Port bits read zero while the buffer is off.
        state_d.posPort = !state_d.posDigDisable && posPinSync;                 // [RULE_15]
        state_d.negPort = !state_d.negDigDisable && negPinSync;                 // [RULE_15]
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q               <= '0;
            state_q.compDisable   <= ACC_RST_CTRL_STATUS[ACC_BIT_DISABLE];
            state_q.bandgapSel    <= ACC_RST_CTRL_STATUS[ACC_BIT_BANDGAP];
            state_q.intEnable     <= ACC_RST_CTRL_STATUS[ACC_BIT_INT_EN];
            state_q.capEnable     <= ACC_RST_CTRL_STATUS[ACC_BIT_CAP_EN];
            state_q.edgeSel       <= ACC_EDGE_TOGGLE;
            state_q.muxEnable     <= ACC_RST_CONV_CTRL_B[ACC_BIT_MUX_EN];
            state_q.trigSel       <= ACC_RST_CONV_CTRL_B[ACC_BIT_TRIG_HI:0];
            state_q.outPinEnable  <= ACC_RST_OUT_CTRL[ACC_BIT_OUT_EN];
            state_q.negDigDisable <= ACC_RST_DIG_DISABLE[ACC_BIT_NEG_DDIS];
            state_q.posDigDisable <= ACC_RST_DIG_DISABLE[ACC_BIT_POS_DDIS];
            state_q.irqStatus     <= ACC_RST_IRQ;
            state_q.irqMask       <= ACC_RST_IRQ;
            state_q.phase         <= ACC_PH_IDLE;
            state_q.rsp.hreadyout <= 1'b1;
            state_q.rsp.hresp     <= ACC_HRESP_OKAY;
        end else begin
            state_q <= state_d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------

    // Outputs come from the state register.
    assign ahbRsp                 = state_q.rsp;
    assign analogCtrl             = state_q.analog;
    assign converterTriggerSelect = state_q.trigSel;
    assign compIntRequest         = state_q.intReq;
    assign irqLine                = state_q.irq;
    assign captureSelect          = state_q.capSel;
    assign captureSignal          = state_q.capSig;
    assign compOutPin             = state_q.outPin;
    assign compOutPinOe           = state_q.outPinOe;
    assign posPortBit             = state_q.posPort;
    assign negPortBit             = state_q.negPort;

endmodule // acc_comparator_control
`default_nettype wire

/* rtl/acc_pkg.sv */
//----------------------------------------------------------------------------------------------
// Functional notes
// RULE_01 - Raw result is one when positive input exceeds negative input.
// RULE_02 - Mux enabled, converter off: channel_select picks negative channel 0..7.
// RULE_03 - Mux enable is bit 6 of converter ctrl B; reset zero selects the pin.
// RULE_04 - Output enable, bit 0, drives the result onto the output pin.
// RULE_05 - Disable, bit 7, switches comparator power off; resets to zero.
// RULE_06 - Bit 6 puts the internal reference on the positive input.
// RULE_07 - Read-only bit 5 shows the result through a 1-2 cycle synchroniser.
// RULE_08 - Flag bit 4 sets on the selected edge, enabled or not.
// RULE_09 - Vector taken or a written one clears the flag.
// RULE_10 - Request while flag, enable bit 3 and global enable are set.
// RULE_11 - Bit 2 routes the result to timer input capture.
// RULE_12 - Edge select bits 1:0: 00 toggle, 01 reserved, 10 falling, 11 rising.
// RULE_13 - Software clears the enable before changing edge select.
// RULE_14 - Software clears the enable before changing the disable bit.
// RULE_15 - Input disable bits 1 and 0 force that pin's port bit to zero.
// RULE_16 - Unused input-disable and output-enable bits read zero.
// RULE_17 - Software clears converter power reduction before using its mux.
// RULE_18 - Request comes from flag and enable, vectored under global enable.
// RULE_19 - Edges are found by comparing consecutive synchronised samples.
//----------------------------------------------------------------------------------------------
package acc_pkg;

    // Register indices; byte address is four times index.
    localparam logic [7:0] ACC_IDX_CTRL_STATUS = 8'h50;
    localparam logic [7:0] ACC_IDX_OUT_CTRL    = 8'h51;
    localparam logic [7:0] ACC_IDX_IRQ_STATUS  = 8'h52;
    localparam logic [7:0] ACC_IDX_IRQ_MASK    = 8'h53;
    localparam logic [7:0] ACC_IDX_CONV_CTRL_B = 8'h7B;
    localparam logic [7:0] ACC_IDX_DIG_DISABLE = 8'h7F;

    // Status register fields.
    localparam int ACC_BIT_DISABLE = 7;
    localparam int ACC_BIT_BANDGAP = 6;
    localparam int ACC_BIT_OUTPUT  = 5;
    localparam int ACC_BIT_FLAG    = 4;
    localparam int ACC_BIT_INT_EN  = 3;
    localparam int ACC_BIT_CAP_EN  = 2;
    localparam int ACC_BIT_EDGE_HI = 1;
    localparam int ACC_BIT_EDGE_LO = 0;

    // Other register fields.
    localparam int ACC_BIT_MUX_EN   = 6;
    localparam int ACC_BIT_TRIG_HI  = 2;
    localparam int ACC_BIT_OUT_EN   = 0;
    localparam int ACC_BIT_NEG_DDIS = 1;
    localparam int ACC_BIT_POS_DDIS = 0;

    // Interrupt status bits: edge event, result change.
    localparam int ACC_EVT_EDGE   = 0;
    localparam int ACC_EVT_CHANGE = 1;

    // Values after reset.
    localparam logic [7:0] ACC_RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ACC_RST_CONV_CTRL_B = 8'h00;
    localparam logic [7:0] ACC_RST_DIG_DISABLE = 8'h00;
    localparam logic [7:0] ACC_RST_OUT_CTRL    = 8'h00;
    localparam logic [1:0] ACC_RST_IRQ         = 2'h0;
    localparam logic [1:0] ACC_RST_EDGE_SEL    = 2'h0;

    // Edge selection codes.
    typedef enum logic [1:0] {
        ACC_EDGE_TOGGLE   = 2'b00,
        ACC_EDGE_RESERVED = 2'b01,
        ACC_EDGE_FALLING  = 2'b10,
        ACC_EDGE_RISING   = 2'b11
    } acc_edge_type;

    // Bus data phase state.
    typedef enum logic [1:0] {
        ACC_PH_IDLE  = 2'b00,
        ACC_PH_WRITE = 2'b01,
        ACC_PH_READ  = 2'b10
    } acc_phase_type;

    // AHB-Lite codes.
    localparam logic [1:0] ACC_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] ACC_HTRANS_SEQ    = 2'b11;
    localparam logic       ACC_HRESP_OKAY    = 1'b0;

    // AHB-Lite request.
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } acc_ahb_req_type;

    // AHB-Lite response.
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } acc_ahb_rsp_type;

    // Controls to the comparator core and converter mux.
    typedef struct packed {
        logic       powerOff;
        logic       posBandgap;
        logic       negFromMux;
        logic [2:0] negChannel;
    } acc_analog_type;

endpackage : acc_pkg

/* rtl/acc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Two-stage synchroniser for independent levels.
// -----------------------------------------------------------------------------
module acc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // Levels.
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule // acc_sync
`default_nettype wire

/* testbench/acc_analog_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Behavioural comparator core.
module acc_analog_model #(
    parameter logic [7:0] BG_LEVEL = 8'h80
) (
    // Controls and analog levels.
    input  wire acc_pkg::acc_analog_type analogCtrl,
    input  wire logic [7:0]              posV,
    input  wire logic [7:0]              negV,
    input  wire logic [7:0][7:0]         chV,
    output var  logic                    rawResult
);
    import acc_pkg::*;
    // Select, gate and compare.
    always_comb begin
        rawResult = !analogCtrl.powerOff &&
            ((analogCtrl.posBandgap ? BG_LEVEL : posV) >
            (analogCtrl.negFromMux ? chV[analogCtrl.negChannel] : negV));
    end
endmodule // acc_analog_model
`default_nettype wire

/* testbench/acc_comparator_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_comparator_control_bench;
    import acc_pkg::*;
    logic clk_sys, nrst, converterEnable, globalIntEnable, vectorTaken, posPinDigital, negPinDigital;
    logic rawResult, compIntRequest, irqLine, captureSelect, captureSignal, compOutPin, compOutPinOe;
    logic posPortBit, negPortBit;
    logic [2:0] channelSelect, trig;
    logic [7:0] pv, nv;
    logic [7:0][7:0] cv;
    logic [31:0] rd;
    int miscompares, compares;
    acc_ahb_req_type m;
    acc_ahb_rsp_type ahbRsp;
    acc_analog_type analogCtrl;
    // hreadyout doubles as the bus hready.
    acc_analog_model u_core (.analogCtrl, .posV(pv), .negV(nv), .chV(cv), .rawResult);
    acc_comparator_control u_dut (.clk_sys, .nrst, .ahbReq({m[$bits(m)-1:1], ahbRsp.hreadyout}), .ahbRsp,
        .rawResult, .analogCtrl, .converterEnable, .channelSelect, .converterTriggerSelect(trig), .globalIntEnable,
        .vectorTaken, .compIntRequest, .irqLine, .captureSelect, .captureSignal, .compOutPin, .compOutPinOe,
        .posPinDigital, .negPinDigital, .posPortBit, .negPortBit);
    // Report and end the run.
    task automatic tally_and_finish(input bit hung);
        if (hung) miscompares++;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bounded wait for hready at a rising edge.
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 50) tally_and_finish(1'h1);
        end while (ahbRsp.hreadyout !== 1'h1);
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        m <= '{1'h1, {22'h00_0000, idx, 2'h0}, ACC_HTRANS_NONSEQ, w, 3'h2, m.hwdata, 1'h1};
        wt();
        m.htrans <= 2'h0;
        m.hwdata <= wd;
        wt();
        rd = ahbRsp.hrdata;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        bus(1'h0, idx, 32'h0000_0000);
        chk(rd[7:0], e);
    endtask
    task automatic t_edge();
        logic [7:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 8'(i);
            bus(1'h1, ACC_IDX_CTRL_STATUS, 32'(c | 8'h10));
            pv <= 8'hC8;
            repeat (6) @(posedge clk_sys);
            rdchk(ACC_IDX_CTRL_STATUS, c | 8'h20 | ((i == 0 || i == 3) ? 8'h10 : 8'h00));
            bus(1'h1, ACC_IDX_CTRL_STATUS, 32'(c | 8'h10));
            pv <= 8'h00;
            repeat (6) @(posedge clk_sys);
            rdchk(ACC_IDX_CTRL_STATUS, c | ((i == 0 || i == 2) ? 8'h10 : 8'h00));
        end
    endtask
    task automatic t_irq();
        globalIntEnable <= 1'h1;
        bus(1'h1, ACC_IDX_IRQ_MASK, 32'h0000_0001);
        bus(1'h1, ACC_IDX_IRQ_STATUS, 32'h0000_0003);
        bus(1'h1, ACC_IDX_CTRL_STATUS, 32'h0000_001B);
        pv <= 8'hC8;
        repeat (6) @(posedge clk_sys);
        chk({6'h00, compIntRequest, irqLine}, 8'h03);
        vectorTaken <= 1'h1;
        @(posedge clk_sys);
        vectorTaken <= 1'h0;
        bus(1'h1, ACC_IDX_IRQ_STATUS, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        chk({6'h00, compIntRequest, irqLine}, 8'h00);
        bus(1'h1, ACC_IDX_CTRL_STATUS, 32'h0000_0001);
    endtask
    task automatic t_analog();
        pv <= 8'h64;
        bus(1'h1, ACC_IDX_CONV_CTRL_B, 32'hFFFF_FFFF);
        rdchk(ACC_IDX_CONV_CTRL_B, 8'h47);
        chk({5'h00, trig}, 8'h07);
        for (int i = 0; i < 8; i++) begin
            channelSelect <= 3'(i);
            repeat (6) @(posedge clk_sys);
            rdchk(ACC_IDX_CTRL_STATUS, (i < 4) ? 8'h21 : 8'h01);
        end
        converterEnable <= 1'h1;
        nv <= 8'h50;
        repeat (6) @(posedge clk_sys);
        rdchk(ACC_IDX_CTRL_STATUS, 8'h21);
        pv <= 8'h00;
        nv <= 8'h70;
        bus(1'h1, ACC_IDX_CTRL_STATUS, 32'h0000_0041);
        repeat (6) @(posedge clk_sys);
        rdchk(ACC_IDX_CTRL_STATUS, 8'h61);
        bus(1'h1, ACC_IDX_CTRL_STATUS, 32'h0000_00C1);
        repeat (6) @(posedge clk_sys);
        rdchk(ACC_IDX_CTRL_STATUS, 8'hC1);
    endtask
    task automatic t_pins();
        pv <= 8'hC8;
        bus(1'h1, ACC_IDX_CTRL_STATUS, 32'h0000_0005);
        bus(1'h1, ACC_IDX_OUT_CTRL, 32'hFFFF_FFFF);
        rdchk(ACC_IDX_OUT_CTRL, 8'h01);
        repeat (6) @(posedge clk_sys);
        chk({2'h0, compOutPinOe, compOutPin, captureSelect, captureSignal, posPortBit, negPortBit}, 8'h3F);
        bus(1'h1, ACC_IDX_DIG_DISABLE, 32'hFFFF_FFFF);
        rdchk(ACC_IDX_DIG_DISABLE, 8'h03);
        repeat (4) @(posedge clk_sys);
        chk({6'h00, posPortBit, negPortBit}, 8'h00);
    endtask
    // Clock, reset, scenarios.
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {nrst, converterEnable, globalIntEnable, vectorTaken, channelSelect, pv, m} = '0;
        {posPinDigital, negPinDigital} = 2'h3;
        nv = 8'h64;
        cv = 64'hD2B4_9678_5A3C_1E00;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'h1;
        rdchk(ACC_IDX_DIG_DISABLE, 8'h00);
        rdchk(8'h60, 8'h00);
        t_edge();
        t_irq();
        t_analog();
        t_pins();
        tally_and_finish(1'h0);
    end
endmodule // acc_comparator_control_bench
`default_nettype wire

/* testbench/acc_comparator_control_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checks.
// ----
module acc_cc_sva (
    input wire logic                    clk_sys,
    input wire logic                    nrst,
    input wire acc_pkg::acc_ahb_req_type ahbReq,
    input wire acc_pkg::acc_ahb_rsp_type ahbRsp,
    input wire logic                    globalIntEnable,
    input wire logic                    compIntRequest,
    input wire logic [2:0]              channelSelect,
    input wire acc_pkg::acc_analog_type analogCtrl,
    input wire logic                    captureSelect,
    input wire logic                    captureSignal,
    input wire logic                    compOutPin,
    input wire logic                    compOutPinOe,
    input wire logic                    rawResult
);
    import acc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Taken read; one wait cycle.
    sequence sRead; ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1] && !ahbReq.hwrite; endsequence
    sequence sWait; !ahbRsp.hreadyout ##1 ahbRsp.hreadyout; endsequence
    // Bus, request and routing checks.
    AST_OKAY: assert property (ahbRsp.hresp == ACC_HRESP_OKAY) else $error("hresp");
    AST_READ_WAIT: assert property (sRead |=> sWait) else $error("read wait");
    AST_WRITE_NOWAIT: assert property (ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1] && ahbReq.hwrite
        |=> ahbRsp.hreadyout) else $error("write wait");
    AST_REQ_GLOBAL: assert property (compIntRequest |-> $past(globalIntEnable)) else $error("req");
    AST_PIN_OE: assert property (compOutPin |-> compOutPinOe) else $error("pin");
    AST_CAP_SEL: assert property (captureSignal |-> captureSelect) else $error("cap");
    AST_CHAN: assert property (analogCtrl.negChannel ==
        (analogCtrl.negFromMux ? $past(channelSelect) : 3'h0)) else $error("chan");
    AST_CAP_FOLLOW: assert property ((captureSelect && rawResult)[*5] |-> captureSignal)
        else $error("follow");
endmodule // acc_cc_sva
bind acc_comparator_control acc_cc_sva u_sva (.clk_sys, .nrst, .ahbReq, .ahbRsp, .globalIntEnable,
    .compIntRequest, .channelSelect, .analogCtrl, .captureSelect, .captureSignal, .compOutPin, .compOutPinOe,
    .rawResult);
`default_nettype wire
